// >>> core/fci_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Output word is read straight from the storage flops.
`timescale 1ns/10ps
module fci_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg, rd_reg;
   logic push, pop;

   assign o_valid = wr_reg != rd_reg;
   assign o_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
   assign o_data = mem_reg[rd_reg[AW-1:0]];
   assign push = i_valid && o_ready;
   assign pop = i_ready && o_valid;

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= i_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule // fci_fifo

// >>> core/fci_pkg.sv
// Purpose: Shared constants and types of the flash card interface.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register.
// Notes: Config layout doubles as the readback image; unused bits stay zero.
package fci_pkg;
   localparam logic [11:0] FCI_OFS_CONFIG = 12'h460;
   localparam logic [11:0] FCI_OFS_CMD1 = 12'h464;
   localparam logic [11:0] FCI_OFS_CMD2 = 12'h468;
   localparam logic [11:0] FCI_OFS_DATA1 = 12'h46c;
   localparam logic [11:0] FCI_OFS_DATA2 = 12'h470;
   localparam logic [11:0] FCI_OFS_STATUS = 12'h474;
   localparam logic [11:0] FCI_OFS_IRQ_EN = 12'h478;
   localparam logic [11:0] FCI_OFS_IRQ_ST = 12'h47c;
   localparam logic [31:0] FCI_CONFIG_MASK = 32'h003b_ffff;
   localparam logic [7:0] FCI_PERIOD_RST = 8'h0f;
   localparam logic [5:0] FCI_WORD_BITS = 6'h20;
   localparam int FCI_FIFO_DEPTH = 4;
   localparam int FCI_CMD_LEFT_LSB = 0;
   localparam int FCI_CMD_CODE_LSB = 16;

   typedef enum logic [1:0] {FCI_FZ_RUN = 2'h0, FCI_FZ_LOW = 2'h1, FCI_FZ_HIGH = 2'h2, FCI_FZ_ILL = 2'h3} fci_freeze_e;
   typedef enum logic [1:0] {FCI_FAM_STICK = 2'h0, FCI_FAM_LINE1 = 2'h1, FCI_FAM_RSV = 2'h2, FCI_FAM_LINE4 = 2'h3} fci_family_e;
   typedef enum logic [3:0] {FCI_CMD_NONE = 4'h0, FCI_CMD_READ = 4'h1, FCI_CMD_WRITE = 4'h2} fci_cmd_e;
   // Gray codes: idle to either transfer state flips one bit
   typedef enum logic [1:0] {FCI_ST_IDLE = 2'h0, FCI_ST_TX = 2'h1, FCI_ST_RX = 2'h2} fci_ch_e;

   typedef struct packed {
      logic [9:0] zero_hi;
      fci_family_e family;
      logic edge_fall;
      logic rsvd;
      fci_freeze_e freeze;
      logic [7:0] high;
      logic [7:0] low;
   } fci_cfg_s;

   localparam fci_cfg_s FCI_CFG_RST = '{zero_hi: 10'h000, family: FCI_FAM_STICK, edge_fall: 1'b0, rsvd: 1'b0,
      freeze: FCI_FZ_LOW, high: FCI_PERIOD_RST, low: FCI_PERIOD_RST};

   typedef struct packed {
      logic [11:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } fci_avs_req_s;
endpackage

// >>> core/fci_top.sv
// Purpose: Flash card interface core: card clock generator, register file, two serial channels.
// Assumes: Card clock is made here from i_mclk; card data pins are asynchronous.
// Notes: Synchronised data lag two mclk cycles, so a sample sees the level just before the edge.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
// What this block does
// RQ1 - Serves one card family at a time
// RQ2 - One clock generator, bus unit, two channels
// RQ3 - Stick mode: channels independent, share clock only
// RQ4 - Line-card: channel 1 data lines, channel 2 command
// RQ5 - Eight 32-bit registers from offset 0x460
// RQ6 - 0x47C reads status, write clears chosen flags
// RQ7 - Interrupt enable at 0x478 gates the request
// RQ8 - Clock low lasts low count plus one
// RQ9 - Clock high lasts high count plus one
// RQ10 - Freeze field: run, hold low, hold high
// RQ11 - Sample edge bit picks falling or rising
// RQ12 - Family field: stick, one line, four lines
// RQ13 - Stretch clock when data pin turns around
// RQ14 - Halt clock on buffer overrun or underrun
// RQ15 - Clock fields change live without glitches
// RQ16 - Software picks sample edge per family
// RQ17 - Reserved config bits read zero, ignore writes
// RQ18 - Down-counter reloaded at each clock transition
module fci_top import fci_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire fci_avs_req_s i_avs,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [7:0] i_dat,
   output logic [7:0] o_dat,
   output logic [7:0] o_dat_oe_n,
   output logic o_sclk,
   output logic o_irq
);
   fci_cfg_s cfg_reg;
   logic [7:0] cnt_reg, dat_s1_reg, dat_s2_reg;
   logic sclk_reg, ack_reg, irq_reg;
   logic [3:0] irq_st_reg, irq_en_reg;
   logic [1:0] cap_full_reg;
   logic [31:0] rd_next;
   logic req, wr, rd, blocked, expire, rise_ev, fall_ev, smp_ev, stretch_ev, frz_lo, frz_hi;
   logic sel_cfg, sel_stat, sel_ien, sel_ist;
   logic [1:0] sel_cmd, sel_dat;
   wire [1:0] stall_w, turn_w, rdy_w, rxf_w;
   wire [3:0] irq_set;
   wire [7:0] stat_w;
   wire [31:0] cmd_rd [2];
   wire [31:0] rxb_rd [2];
   wire [7:0] low_w = cfg_reg.low;
   wire [7:0] high_w = cfg_reg.high;

   // Bus slave: one wait state, longer while a data write meets a full FIFO
   assign req = i_avs.read || i_avs.write;
   assign sel_cfg = i_avs.address == FCI_OFS_CONFIG; // see RQ5
   assign sel_cmd = {i_avs.address == FCI_OFS_CMD2, i_avs.address == FCI_OFS_CMD1};
   assign sel_dat = {i_avs.address == FCI_OFS_DATA2, i_avs.address == FCI_OFS_DATA1};
   assign sel_stat = i_avs.address == FCI_OFS_STATUS;
   assign sel_ien = i_avs.address == FCI_OFS_IRQ_EN;
   assign sel_ist = i_avs.address == FCI_OFS_IRQ_ST;
   assign blocked = i_avs.write && |(sel_dat & ~rdy_w);
   assign o_waitrequest = req && !ack_reg;
   assign wr = i_avs.write && ack_reg;
   assign rd = i_avs.read && ack_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req && !ack_reg && !blocked;
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      unique case (1'b1)
         sel_cfg: rd_next = cfg_reg;
         sel_cmd[0]: rd_next = cmd_rd[0];
         sel_cmd[1]: rd_next = cmd_rd[1];
         sel_dat[0]: rd_next = rxb_rd[0];
         sel_dat[1]: rd_next = rxb_rd[1];
         sel_stat: rd_next = {24'h00_0000, stat_w};
         sel_ien: rd_next = {28'h000_0000, irq_en_reg};
         sel_ist: rd_next = {28'h000_0000, irq_st_reg}; // see RQ6
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // Capture the full flags with the data so a read only pops the word it returned
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_readdata <= 32'h0000_0000;
         cap_full_reg <= 2'h0;
      end else if (i_avs.read && !ack_reg) begin
         o_readdata <= rd_next;
         cap_full_reg <= rxf_w;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_reg <= FCI_CFG_RST;
      end else if (wr && sel_cfg) begin
         cfg_reg <= fci_cfg_s'(i_avs.writedata & FCI_CONFIG_MASK); // see RQ17
      end
   end

   // Events set, software clears with ones; a new event wins over its clear
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_st_reg <= 4'h0;
         irq_en_reg <= 4'h0;
         irq_reg <= 1'b0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~((wr && sel_ist) ? i_avs.writedata[3:0] : 4'h0)) | irq_set; // see RQ6
         if (wr && sel_ien) begin
            irq_en_reg <= i_avs.writedata[3:0];
         end
         irq_reg <= |(irq_st_reg & irq_en_reg); // see RQ7
      end
   end
   assign o_irq = irq_reg;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dat_s1_reg <= 8'h00;
         dat_s2_reg <= 8'h00;
      end else begin
         dat_s1_reg <= i_dat;
         dat_s2_reg <= dat_s1_reg;
      end
   end

   // Card clock: transitions only at counter expiry, so live edits never cut a phase short
   assign expire = cnt_reg == 8'h00;
   assign frz_hi = cfg_reg.freeze == FCI_FZ_HIGH;
   assign frz_lo = !frz_hi && cfg_reg.freeze != FCI_FZ_RUN; // see RQ10
   assign stretch_ev = expire && !sclk_reg && |turn_w && !(|stall_w); // see RQ13
   assign rise_ev = expire && !sclk_reg && !frz_lo && !(|stall_w) && !(|turn_w); // see RQ14
   assign fall_ev = expire && sclk_reg && !frz_hi && !(|stall_w); // see RQ14
   assign smp_ev = cfg_reg.edge_fall ? fall_ev : rise_ev; // see RQ11

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= FCI_PERIOD_RST;
         sclk_reg <= 1'b0;
      end else if (rise_ev) begin
         cnt_reg <= cfg_reg.high; // see RQ9
         sclk_reg <= 1'b1;
      end else if (fall_ev) begin
         cnt_reg <= cfg_reg.low; // see RQ8
         sclk_reg <= 1'b0;
      end else if (stretch_ev) begin
         cnt_reg <= cfg_reg.low;
      end else if (!expire) begin
         cnt_reg <= cnt_reg - 8'h01; // see RQ18
      end
   end
   assign o_sclk = sclk_reg; // see RQ15

   // Two channels sharing the clock generator, the bus slave and the config register
   for (genvar c = 0; c < 2; c++) begin : g_ch // see RQ2
      fci_ch_e st_reg;
      logic [15:0] left_reg;
      logic [3:0] code_reg, dout_reg;
      logic [31:0] sh_reg, rxb_reg;
      logic [5:0] wb_reg;
      logic rxf_reg, hold_reg, dir_reg, turn_reg, oe_n_reg, busy_d_reg;
      logic [31:0] fifo_dat;
      logic fifo_vld, fifo_rdy, fifo_pop;
      logic wide, cmd_wr, rx_samp, word_done, xfer, pop_rx, new_dir;
      logic [5:0] step, len, cur;
      logic [3:0] din;
      logic [31:0] rx_shift;

      // Only channel 1 may use four lines, and only in the four-line family
      assign wide = (c == 0) && cfg_reg.family == FCI_FAM_LINE4; // see RQ4
      assign step = wide ? 6'h04 : 6'h01; // see RQ12
      assign din = dat_s2_reg[c*4 +: 4];
      assign len = (left_reg[4:0] == 5'h00) ? FCI_WORD_BITS : {1'b0, left_reg[4:0]};
      assign cur = (wb_reg == 6'h00) ? len : wb_reg;
      assign cmd_wr = wr && sel_cmd[c];
      assign new_dir = i_avs.writedata[19:16] == FCI_CMD_WRITE;
      assign rx_shift = wide ? {sh_reg[27:0], din} : {sh_reg[30:0], din[0]};
      assign rx_samp = st_reg == FCI_ST_RX && smp_ev && !hold_reg && left_reg != 16'h0000;
      assign word_done = rx_samp && cur == step;
      assign xfer = (word_done || hold_reg) && !rxf_reg;
      assign pop_rx = rd && sel_dat[c] && cap_full_reg[c];
      assign fifo_pop = st_reg == FCI_ST_TX && wb_reg == 6'h00 && left_reg != 16'h0000 && fifo_vld;

      fci_fifo #(.WIDTH(32), .DEPTH(FCI_FIFO_DEPTH)) u_fifo (
         .i_mclk(i_mclk),
         .i_rst_n(i_rst_n),
         .i_valid(wr && sel_dat[c]),
         .i_data(i_avs.writedata),
         .o_ready(fifo_rdy),
         .o_valid(fifo_vld),
         .o_data(fifo_dat),
         .i_ready(fifo_pop)
      );

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            st_reg <= FCI_ST_IDLE;
            left_reg <= 16'h0000;
            code_reg <= 4'h0;
            sh_reg <= 32'h0000_0000;
            wb_reg <= 6'h00;
            hold_reg <= 1'b0;
            dout_reg <= 4'h0;
            oe_n_reg <= 1'b1;
         end else if (cmd_wr) begin
            left_reg <= i_avs.writedata[FCI_CMD_CODE_LSB-1:FCI_CMD_LEFT_LSB];
            code_reg <= i_avs.writedata[19:16];
            wb_reg <= 6'h00;
            hold_reg <= 1'b0;
            oe_n_reg <= !(new_dir && i_avs.writedata[15:0] != 16'h0000);
            if (i_avs.writedata[15:0] == 16'h0000) begin
               st_reg <= FCI_ST_IDLE;
            end else if (new_dir) begin
               st_reg <= FCI_ST_TX;
            end else if (i_avs.writedata[19:16] == FCI_CMD_READ) begin
               st_reg <= FCI_ST_RX;
            end else begin
               st_reg <= FCI_ST_IDLE;
            end
         end else begin
            unique case (st_reg)
               FCI_ST_IDLE: begin
                  oe_n_reg <= 1'b1;
               end
               FCI_ST_TX: begin
                  if (fifo_pop) begin
                     sh_reg <= fifo_dat;
                     wb_reg <= len;
                  end else if (fall_ev && wb_reg != 6'h00) begin
                     dout_reg <= wide ? sh_reg[31:28] : {3'h0, sh_reg[31]};
                     sh_reg <= wide ? {sh_reg[27:0], 4'h0} : {sh_reg[30:0], 1'b0};
                     wb_reg <= wb_reg - step;
                     left_reg <= left_reg - {10'h000, step};
                  end else if (rise_ev && left_reg == 16'h0000) begin
                     // Last bit stays on the pin until the card has clocked it in
                     st_reg <= FCI_ST_IDLE;
                  end
               end
               FCI_ST_RX: begin
                  if (rx_samp) begin
                     sh_reg <= rx_shift;
                     wb_reg <= cur - step;
                     left_reg <= left_reg - {10'h000, step};
                     hold_reg <= word_done && rxf_reg;
                     if (left_reg == {10'h000, step} && !(word_done && rxf_reg)) begin
                        st_reg <= FCI_ST_IDLE;
                     end
                  end else if (hold_reg && !rxf_reg) begin
                     hold_reg <= 1'b0;
                     if (left_reg == 16'h0000) begin
                        st_reg <= FCI_ST_IDLE;
                     end
                  end
               end
               default: st_reg <= FCI_ST_IDLE;
            endcase
         end
      end

      // Receive buffer: a word arriving as software empties it is kept
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            rxf_reg <= 1'b0;
            rxb_reg <= 32'h0000_0000;
         end else begin
            if (xfer) begin
               rxb_reg <= hold_reg ? sh_reg : rx_shift;
            end
            rxf_reg <= xfer || (rxf_reg && !pop_rx);
         end
      end

      // A change of direction buys one extra low phase before the next rise
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            dir_reg <= 1'b0;
            turn_reg <= 1'b0;
            busy_d_reg <= 1'b0;
         end else begin
            busy_d_reg <= st_reg != FCI_ST_IDLE;
            if (cmd_wr && i_avs.writedata[15:0] != 16'h0000 && new_dir != dir_reg) begin
               dir_reg <= new_dir;
               turn_reg <= 1'b1; // see RQ13
            end else if (stretch_ev) begin
               turn_reg <= 1'b0;
            end
         end
      end

      // Stall on empty transmit word or on a finished word that has nowhere to go
      assign stall_w[c] = (st_reg == FCI_ST_TX && wb_reg == 6'h00 && left_reg != 16'h0000 && !fifo_vld) || hold_reg; // see RQ14
      assign turn_w[c] = turn_reg;
      assign rdy_w[c] = fifo_rdy;
      assign rxf_w[c] = rxf_reg;
      assign cmd_rd[c] = {12'h000, code_reg, left_reg};
      assign rxb_rd[c] = rxb_reg;
      assign stat_w[c*4 +: 4] = {!fifo_rdy, rxf_reg, !fifo_vld, st_reg != FCI_ST_IDLE};
      assign irq_set[c*2 +: 2] = {xfer, busy_d_reg && st_reg == FCI_ST_IDLE};
      assign o_dat[c*4 +: 4] = dout_reg; // see RQ3
      assign o_dat_oe_n[c*4 +: 4] = wide ? {4{oe_n_reg}} : {3'h7, oe_n_reg}; // see RQ1
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   property p_low_len;
      $fell(o_sclk) |-> cnt_reg == $past(low_w);
   endproperty
   a_low_len: assert property (p_low_len) else $error("low phase count not loaded"); // see RQ8
   property p_high_len;
      $rose(o_sclk) |-> cnt_reg == $past(high_w) ##1 (o_sclk || $past(cnt_reg) == 8'h00);
   endproperty
   a_high_len: assert property (p_high_len) else $error("high phase count wrong"); // see RQ9
   property p_frz_low;
      (cfg_reg.freeze == FCI_FZ_LOW && !o_sclk) |=> !o_sclk;
   endproperty
   a_frz_low: assert property (p_frz_low) else $error("clock rose while frozen low"); // see RQ10
   property p_frz_high;
      (frz_hi && o_sclk) |=> o_sclk;
   endproperty
   a_frz_high: assert property (p_frz_high) else $error("clock fell while frozen high"); // see RQ10
   property p_no_glitch;
      $changed(o_sclk) |-> $past(cnt_reg) == 8'h00;
   endproperty
   a_no_glitch: assert property (p_no_glitch) else $error("clock moved before phase end"); // see RQ15
   property p_stall;
      (|stall_w && expire) |=> $stable(o_sclk);
   endproperty
   a_stall: assert property (p_stall) else $error("clock moved during stall"); // see RQ14
   property p_turn;
      (|turn_w && expire && !o_sclk) |=> !o_sclk;
   endproperty
   a_turn: assert property (p_turn) else $error("clock rose before turnaround"); // see RQ13
   property p_cfg_mask;
      (wr && sel_cfg) |=> (cfg_reg == ($past(i_avs.writedata) & FCI_CONFIG_MASK)) && !cfg_reg.rsvd;
   endproperty
   a_cfg_mask: assert property (p_cfg_mask) else $error("config write not masked"); // see RQ17
   property p_irq;
      o_irq == |($past(irq_st_reg) & $past(irq_en_reg));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not gated by enable"); // see RQ7
   property p_clear;
      (wr && sel_ist && i_avs.writedata[0] && !irq_set[0]) |=> !irq_st_reg[0];
   endproperty
   a_clear: assert property (p_clear) else $error("status flag not cleared"); // see RQ6
   property p_narrow;
      (cfg_reg.family != FCI_FAM_LINE4) |-> o_dat_oe_n[3:1] == 3'h7 && o_dat_oe_n[7:5] == 3'h7;
   endproperty
   a_narrow: assert property (p_narrow) else $error("unused data line driven"); // see RQ12

   c_fall: cover property ($fell(o_sclk));
   c_stall: cover property (|stall_w && expire);
   c_turn: cover property (stretch_ev);
   c_irq: cover property ($rose(o_irq));
endmodule // fci_top

// >>> sim/fci_card_model.sv
// Purpose: Behavioural flash card on the far side of the serial pins.
// Assumes: One bit per card clock; channel 1 on pin 0, channel 2 on pin 4.
// Notes: Released pins float to the pull-up level and read 1, except pin 4, which the card drives.
`timescale 1ns/10ps
module fci_card_model (
   input wire logic i_sclk,
   input wire logic [7:0] i_dat_dev,
   input wire logic [7:0] i_oe_n,
   input wire logic i_load,
   input wire logic [7:0] i_tx_byte,
   output logic [7:0] o_pins,
   output logic [7:0] o_rx_byte,
   output logic [5:0] o_rx_cnt
);
   logic [7:0] shift_reg;
   initial begin
      shift_reg = 8'hff;
      o_rx_byte = 8'h00;
      o_rx_cnt = 6'h00;
   end
   // Card puts the first bit out at once and the next after each fall
   always @(posedge i_load) begin
      shift_reg = i_tx_byte;
      o_rx_cnt = 6'h00;
   end
   always @(negedge i_sclk) begin
      if (i_oe_n[4]) begin
         shift_reg = {shift_reg[6:0], 1'b1};
      end
   end
   // Card takes bits from the device at the rising clock edge
   always @(posedge i_sclk) begin
      if (!i_oe_n[0]) begin
         o_rx_byte = {o_rx_byte[6:0], i_dat_dev[0]};
         o_rx_cnt = o_rx_cnt + 6'h01;
      end
   end
   // Wire level: device wins where it drives, else card or pull-up
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_pins[k] = !i_oe_n[k] ? i_dat_dev[k] : ((k == 4) ? shift_reg[7] : 1'b1);
      end
   end
endmodule // fci_card_model

// >>> sim/tb.sv
// Purpose: Self-checking bench of the flash card interface core.
// Assumes: Register bus answers after waitrequest drops; card model on pins.
// Notes: Transfers start from a frozen clock so the first edge is known.
`timescale 1ns/10ps
module tb import fci_pkg::*;;
   logic i_mclk;
   logic i_rst_n;
   fci_avs_req_s avs;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic [7:0] pins;
   logic [7:0] o_dat;
   logic [7:0] o_dat_oe_n;
   logic o_sclk;
   logic o_irq;
   logic load;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic [5:0] rx_cnt;
   logic [31:0] rd;
   int n_mismatch = 0;
   int checks = 0;

   fci_top fci_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs(avs), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .i_dat(pins), .o_dat(o_dat), .o_dat_oe_n(o_dat_oe_n),
      .o_sclk(o_sclk), .o_irq(o_irq));
   fci_card_model fci_card_model_i (.i_sclk(o_sclk), .i_dat_dev(o_dat), .i_oe_n(o_dat_oe_n),
      .i_load(load), .i_tx_byte(tx_byte), .o_pins(pins), .o_rx_byte(rx_byte), .o_rx_cnt(rx_cnt));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   task automatic wrap_up();
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request holds until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge i_mclk);
      avs.address <= a;
      avs.read <= !wr;
      avs.write <= wr;
      avs.writedata <= wd;
      for (k = 0; k < 100; k++) begin
         @(posedge i_mclk);
         if (o_waitrequest === 1'b0) break;
      end
      rd = o_readdata;
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      if (k == 100) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   task automatic poll(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] want);
      int k;
      for (k = 0; k < 400; k++) begin
         bus(1'b0, a, 32'h0);
         if ((rd & mask) === want) break;
      end
      if (k == 400) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   // Counts samples of one whole clock phase at the given level
   task automatic meas(input logic lvl, input int exp);
      int n;
      for (n = 0; n < 300 && o_sclk === lvl; n++) @(posedge i_mclk);
      for (n = 0; n < 300 && o_sclk !== lvl; n++) @(posedge i_mclk);
      for (n = 0; n < 300 && o_sclk === lvl; n++) @(posedge i_mclk);
      chk(n, exp);
   endtask

   task automatic t_reset();
      bus(1'b0, FCI_OFS_CONFIG, 32'h0);
      chk(rd, 32'h0001_0f0f);
      repeat (40) @(posedge i_mclk);
      chk(o_sclk, 1'b0);
      chk(o_dat_oe_n, 8'hff);
      bus(1'b0, FCI_OFS_IRQ_ST, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 12'h400, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, FCI_OFS_CONFIG, 32'hffff_ffff);
      bus(1'b0, FCI_OFS_CONFIG, 32'h0);
      chk(rd, 32'h003b_ffff);
   endtask

   // Period fields, then a live rewrite while the clock runs
   task automatic t_period();
      bus(1'b1, FCI_OFS_CONFIG, 32'h0000_0402);
      meas(1'b1, 5);
      meas(1'b0, 3);
      bus(1'b1, FCI_OFS_CONFIG, 32'h0000_0101);
      repeat (12) @(posedge i_mclk);
      meas(1'b1, 2);
      meas(1'b0, 2);
   endtask

   task automatic t_tx();
      bus(1'b1, FCI_OFS_CONFIG, 32'h0002_0202);
      repeat (20) @(posedge i_mclk);
      chk(o_sclk, 1'b1);
      load <= 1'b1;
      bus(1'b1, FCI_OFS_IRQ_EN, 32'h0);
      bus(1'b1, FCI_OFS_CMD1, 32'h0002_0008);
      bus(1'b1, FCI_OFS_DATA1, 32'ha500_0000);
      load <= 1'b0;
      chk(o_dat_oe_n[0], 1'b0);
      bus(1'b1, FCI_OFS_CONFIG, 32'h0000_0202);
      poll(FCI_OFS_STATUS, 32'h1, 32'h0);
      chk(rx_byte, 8'ha5);
      chk(rx_cnt, 6'h08);
      chk(o_irq, 1'b0);
      bus(1'b1, FCI_OFS_IRQ_EN, 32'h1);
      repeat (3) @(posedge i_mclk);
      chk(o_irq, 1'b1);
      bus(1'b1, FCI_OFS_IRQ_ST, 32'h1);
      repeat (3) @(posedge i_mclk);
      chk(o_irq, 1'b0);
   endtask

   task automatic t_rx();
      bus(1'b1, FCI_OFS_CONFIG, 32'h0001_0202);
      repeat (20) @(posedge i_mclk);
      chk(o_sclk, 1'b0);
      tx_byte <= 8'h3c;
      load <= 1'b1;
      bus(1'b1, FCI_OFS_CMD2, 32'h0001_0008);
      load <= 1'b0;
      bus(1'b1, FCI_OFS_CONFIG, 32'h0000_0202);
      poll(FCI_OFS_STATUS, 32'h40, 32'h40);
      bus(1'b0, FCI_OFS_IRQ_ST, 32'h0);
      chk(rd & 32'h8, 32'h8);
      bus(1'b0, FCI_OFS_DATA2, 32'h0);
      chk(rd & 32'hff, 32'h3c);
      bus(1'b0, FCI_OFS_STATUS, 32'h0);
      chk(rd & 32'h40, 32'h0);
      bus(1'b1, FCI_OFS_IRQ_ST, 32'hf);
      bus(1'b0, FCI_OFS_IRQ_ST, 32'h0);
      chk(rd, 32'h0);
   endtask

   // Command line in the four-line family, sampled on the falling edge
   task automatic t_rx_fall();
      bus(1'b1, FCI_OFS_CONFIG, 32'h0039_0202);
      repeat (20) @(posedge i_mclk);
      tx_byte <= 8'h96;
      load <= 1'b1;
      bus(1'b1, FCI_OFS_CMD2, 32'h0001_0008);
      load <= 1'b0;
      bus(1'b1, FCI_OFS_CONFIG, 32'h0038_0202);
      poll(FCI_OFS_STATUS, 32'h40, 32'h40);
      bus(1'b0, FCI_OFS_DATA2, 32'h0);
      chk(rd & 32'hff, 32'h96);
      bus(1'b1, FCI_OFS_CMD1, 32'h0002_0008);
      @(posedge i_mclk);
      chk(o_dat_oe_n, 8'hf0);
      bus(1'b1, FCI_OFS_CMD1, 32'h0000_0000);
      @(posedge i_mclk);
      chk(o_dat_oe_n, 8'hff);
   endtask

   initial begin
      i_rst_n = 1'b0;
      avs = '0;
      load = 1'b0;
      tx_byte = 8'h00;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_reset();
      t_period();
      t_tx();
      t_rx();
      t_rx_fall();
      wrap_up();
   end
endmodule // tb
